//--- pkg/gia_pkg.sv
package gia_pkg;
    // ========================================================
    // Sizes
    localparam int SRC_N  = 16;
    localparam int GRP_N  = 64;
    localparam int COND_N = 4;
    localparam int GRP_W  = 6;
    localparam int TMR_W  = 16;
    localparam int FN_N   = 4;
    localparam int STAT_W = 2;

    // ========================================================
    // Register byte offsets, 12-bit window
    localparam logic [11:0] OFF_SRC   = 12'h000;
    localparam logic [11:0] OFF_STATE = 12'h400;
    localparam logic [11:0] OFF_CTL   = 12'h800;
    localparam logic [11:0] OFF_SID   = 12'hC00;
    localparam logic [11:0] OFF_ISTAT = 12'hF00;
    localparam logic [11:0] OFF_IMASK = 12'hF04;

    // ========================================================
    // Field positions
    localparam int SRC_MASK0_BIT = 8;
    localparam int SRC_MASK1_BIT = 9;
    localparam int SRC_CEN_LSB   = 16;
    localparam int CTL_ARM_BIT   = 31;
    localparam int SID_FN_LSB    = 5;
    localparam int SID_VEC_W     = 5;
    localparam int EV_FIRE       = 0;
    localparam int EV_BADADDR    = 1;

    // ========================================================
    // Writable bits and values after reset
    localparam logic [31:0] SRC_WMASK = 32'h000F_033F;
    localparam logic [31:0] SRC_RST   = 32'h0000_0300;
    localparam logic [31:0] SID_WMASK = 32'h0000_007F;

    // ========================================================
    // Timer tick period
    localparam int TICK_NS  = 1000;
    localparam int CLK_NS   = 5;
    localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
    localparam int TICK_CW  = $clog2(TICK_CYC);
endpackage : gia_pkg

//--- pkg/gia_grp_if.sv
`timescale 1ns/100ps

// ========================================================
// Control and status of one group
interface gia_grp_if;
    logic                     tick;
    logic                     load;
    logic                     loadArm;
    logic [gia_pkg::TMR_W-1:0] loadTimer;
    logic                     anyFlag;
    logic                     grant;
    logic                     armed;
    logic [gia_pkg::TMR_W-1:0] timer;
    logic                     ready;

    modport ctl (output tick, load, loadArm, loadTimer, anyFlag, grant,
                 input armed, timer, ready);
    modport grp (input tick, load, loadArm, loadTimer, anyFlag, grant,
                 output armed, timer, ready);
endinterface : gia_grp_if

//--- hdl/gia_group.sv
`timescale 1ns/100ps

// ========================================================
// One group: arm bit and hold-off timer
module gia_group
(
    input  wire logic core_clk,
    input  wire logic rstN,
    gia_grp_if.grp    port
);
    logic                      arm_r;
    logic [gia_pkg::TMR_W-1:0] timer_r;

    // Checks run on the core clock, quiet during reset
    default clocking chkClk @(posedge core_clk); endclocking
    default disable iff (!rstN);

    // Arm set by control write, dropped when the interrupt goes out
    always_ff @(posedge core_clk or negedge rstN)
        if (!rstN)
            arm_r <= 1'b0;
        else if (port.load)
            arm_r <= port.loadArm;
        else if (port.grant)
            arm_r <= 1'b0;

    // Countdown, parked at zero
    always_ff @(posedge core_clk or negedge rstN)
        if (!rstN)
            timer_r <= '0;
        else if (port.load)
            timer_r <= port.loadTimer;
        else if (port.tick && timer_r != '0)
            timer_r <= timer_r - 1'b1;

    assign port.armed = arm_r;
    assign port.timer = timer_r;
    // Quiet time elapsed, armed, and something unmasked pending
    assign port.ready = arm_r && timer_r == '0 && port.anyFlag;

    chk_load_capture: assert property (
        port.load |=> arm_r == $past(port.loadArm)
                      && timer_r == $past(port.loadTimer))
        else $error("control write not captured");
    chk_timer_count: assert property (
        port.tick && !port.load && timer_r != '0
        |=> timer_r == $past(timer_r) - 1'b1)
        else $error("timer did not step down");
    chk_timer_floor: assert property (
        !port.load && timer_r == '0 |=> timer_r == '0)
        else $error("timer left zero without a load");
    chk_one_shot: assert property (
        port.grant && !port.load
        |=> !arm_r ##1 (!port.grant || $past(port.load)))
        else $error("group fired twice on one arming");
endmodule : gia_group

//--- hdl/gia_top.sv
`timescale 1ns/100ps

// ========================================================
// Grouped interrupt arm timer, Wishbone register slave
module gia_top
#(
    parameter int SRC_N = gia_pkg::SRC_N,
    parameter int GRP_N = gia_pkg::GRP_N
)
(
    input  wire logic                 core_clk,
    input  wire logic                 nrst,
    input  wire logic [11:0]          wb_adr_i,
    input  wire logic [31:0]          wb_dat_i,
    output      logic [31:0]          wb_dat_o,
    input  wire logic                 wb_we_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    output      logic                 wb_ack_o,
    input  wire logic [SRC_N-1:0][3:0] sourceCondition,
    input  wire logic [3:0]           fnMsiEnable,
    input  wire logic [3:0]           fnMsixEnable,
    output      logic                 sysIntValid,
    output      logic [1:0]           sysIntFunction,
    output      logic [4:0]           sysIntVector,
    output      logic                 sysIntMsi,
    output      logic                 irq
);
    localparam int SRC_AW = $clog2(SRC_N);
    localparam int GRP_AW = $clog2(GRP_N);
    localparam int GW     = gia_pkg::GRP_W;
    localparam int SW     = gia_pkg::STAT_W;

    // ========================================================
    // Declarations
    logic [1:0]                   rstSync_r;
    logic                         rstN;
    logic                         wbAck_r;
    logic [31:0]                  wbDat_r;
    logic                         req;
    logic                         wrEn;
    logic                         hit;
    logic [31:0]                  rdData;
    logic [1:0]                   region;
    logic [7:0]                   idx;
    logic [31:0]                  wrMerged;
    logic [31:0]                  srcCfg_r [SRC_N];
    logic [31:0]                  sid_r    [GRP_N];
    logic [SW-1:0]                stat_r;
    logic [SW-1:0]                mask_r;
    logic [SW-1:0]                statSet;
    logic [SW-1:0]                statClr;
    logic                         irq_r;
    logic [gia_pkg::TICK_CW-1:0]  tickCnt_r;
    logic                         tick_r;
    logic [SRC_N-1:0]             flag0;
    logic [SRC_N-1:0]             flag1;
    logic [2*SRC_N-1:0]           stateView [GRP_N];
    logic [GRP_N-1:0]             anyFlag;
    logic [GRP_N-1:0]             readyVec;
    logic [GRP_N-1:0]             armedVec;
    logic [GRP_N-1:0]             grantVec;
    logic [GRP_AW-1:0]            grantIdx;
    logic                         found;
    logic                         allMasked;
    logic                         sysIntValid_r;
    logic [1:0]                   sysIntFunction_r;
    logic [4:0]                   sysIntVector_r;
    logic                         sysIntMsi_r;
    logic [1:0]                   grantFn;
    logic [gia_pkg::TMR_W-1:0]    timerVec [GRP_N];
    // Assertions share the core clock and the synchronised reset
    default clocking chkClk @(posedge core_clk); endclocking
    default disable iff (!rstN);

    // ========================================================
    // Reset release through two flops
    always_ff @(posedge core_clk or negedge nrst)
        if (!nrst)
            rstSync_r <= 2'h0;
        else
            rstSync_r <= {rstSync_r[0], 1'b1};

    assign rstN = rstSync_r[1];

    // ========================================================
    // Wishbone slave: one wait cycle, ack is a single pulse
    assign req    = wb_cyc_i && wb_stb_i && !wbAck_r;
    assign wrEn   = req && wb_we_i;
    assign region = wb_adr_i[11:10];
    assign idx    = wb_adr_i[9:2];

    // Byte lanes the master did not select keep their old value
    function automatic logic [31:0] gia_merge(
        input logic [31:0] oldV,
        input logic [31:0] newV,
        input logic [3:0]  sel
    );
        logic [31:0] res;
        res = oldV;
        for (int b = 0; b < 4; b++)
            if (sel[b])
                res[8*b +: 8] = newV[8*b +: 8];
        return res;
    endfunction : gia_merge

    always_ff @(posedge core_clk or negedge rstN)
        if (!rstN)
            wbAck_r <= 1'b0;
        else
            wbAck_r <= req;

    // Read data latched at accept; writes return zero
    always_ff @(posedge core_clk or negedge rstN)
        if (!rstN)
            wbDat_r <= 32'h0000_0000;
        else if (req)
            wbDat_r <= wb_we_i ? 32'h0000_0000 : rdData;

    assign wb_ack_o = wbAck_r;
    assign wb_dat_o = wbDat_r;

    // Address decode and read mux; unmapped reads give zero
    always_comb
    begin
        rdData   = 32'h0000_0000;
        hit      = 1'b0;
        wrMerged = 32'h0000_0000;
        case (region)
            2'h0:
                if (idx < SRC_N)
                begin
                    hit      = 1'b1;
                    rdData   = srcCfg_r[idx[SRC_AW-1:0]];
                end
            2'h1:
                if (idx < GRP_N)
                begin
                    hit    = 1'b1;
                    rdData = 32'(stateView[idx[GRP_AW-1:0]]);
                end
            2'h2:
                if (idx < GRP_N)
                begin
                    hit    = 1'b1;
                    rdData = {armedVec[idx[GRP_AW-1:0]], 15'h0000,
                              16'(timerVec[idx[GRP_AW-1:0]])};
                end
            2'h3:
                if (wb_adr_i == gia_pkg::OFF_ISTAT)
                begin
                    hit    = 1'b1;
                    rdData = 32'(stat_r);
                end
                else if (wb_adr_i == gia_pkg::OFF_IMASK)
                begin
                    hit    = 1'b1;
                    rdData = 32'(mask_r);
                end
                else if (idx < GRP_N)
                begin
                    hit    = 1'b1;
                    rdData = sid_r[idx[GRP_AW-1:0]];
                end
            default: hit = 1'b0;
        endcase
        wrMerged = gia_merge(rdData, wb_dat_i, wb_sel_i);
    end

    // ========================================================
    // Source configuration: group number, masks, condition enables
    always_ff @(posedge core_clk or negedge rstN)
        if (!rstN)
        begin
            for (int s = 0; s < SRC_N; s++)
                srcCfg_r[s] <= gia_pkg::SRC_RST;
        end
        else if (wrEn && region == 2'h0 && idx < SRC_N)
            srcCfg_r[idx[SRC_AW-1:0]] <= wrMerged & gia_pkg::SRC_WMASK;

    // Two summary flags per source, each an OR of enabled conditions
    always_comb
        for (int s = 0; s < SRC_N; s++)
        begin
            flag0[s] = |(sourceCondition[s][1:0]
                         & srcCfg_r[s][gia_pkg::SRC_CEN_LSB +: 2]);
            flag1[s] = |(sourceCondition[s][3:2]
                         & srcCfg_r[s][gia_pkg::SRC_CEN_LSB+2 +: 2]);
        end

    // Group view ignores masks; interrupt path honours them
    always_comb
    begin
        allMasked = 1'b1;
        for (int g = 0; g < GRP_N; g++)
        begin
            stateView[g] = '0;
            anyFlag[g]   = 1'b0;
            for (int s = 0; s < SRC_N; s++)
                if (srcCfg_r[s][GW-1:0] == GW'(g))
                begin
                    stateView[g][2*s +: 2] = {flag1[s], flag0[s]};
                    anyFlag[g] = anyFlag[g]
                        | (flag0[s] & ~srcCfg_r[s][gia_pkg::SRC_MASK0_BIT])
                        | (flag1[s] & ~srcCfg_r[s][gia_pkg::SRC_MASK1_BIT]);
                end
        end
        for (int s = 0; s < SRC_N; s++)
            allMasked = allMasked & srcCfg_r[s][gia_pkg::SRC_MASK0_BIT]
                        & srcCfg_r[s][gia_pkg::SRC_MASK1_BIT];
    end

    // ========================================================
    // Timer tick prescaler shared by every group
    always_ff @(posedge core_clk or negedge rstN)
        if (!rstN)
        begin
            tickCnt_r <= gia_pkg::TICK_CW'(gia_pkg::TICK_CYC - 1);
            tick_r    <= 1'b0;
        end
        else if (tickCnt_r == '0)
        begin
            tickCnt_r <= gia_pkg::TICK_CW'(gia_pkg::TICK_CYC - 1);
            tick_r    <= 1'b1;
        end
        else
        begin
            tickCnt_r <= tickCnt_r - 1'b1;
            tick_r    <= 1'b0;
        end

    // ========================================================
    // Per-group state, one instance each
    gia_grp_if gi [GRP_N] ();

    for (genvar g = 0; g < GRP_N; g++)
    begin : g_grp
        // Control write to this group's register loads arm and timer
        assign gi[g].tick      = tick_r;
        assign gi[g].load = wrEn && region == 2'h2 && idx == 8'(g);
        assign gi[g].loadArm   = wrMerged[gia_pkg::CTL_ARM_BIT];
        assign gi[g].loadTimer = wrMerged[gia_pkg::TMR_W-1:0];
        assign gi[g].anyFlag   = anyFlag[g];
        assign gi[g].grant     = grantVec[g];
        assign readyVec[g]     = gi[g].ready;
        assign armedVec[g]     = gi[g].armed;
        assign timerVec[g]     = gi[g].timer;

        gia_group u_grp (
            .core_clk (core_clk),
            .rstN     (rstN),
            .port     (gi[g].grp)
        );
    end

    // System interrupt data, one word per group
    always_ff @(posedge core_clk or negedge rstN)
        if (!rstN)
        begin
            for (int g = 0; g < GRP_N; g++)
                sid_r[g] <= 32'h0000_0000;
        end
        else if (wrEn && region == 2'h3 && idx < GRP_N)
            sid_r[idx[GRP_AW-1:0]] <= wrMerged & gia_pkg::SID_WMASK;

    // ========================================================
    // Fixed priority, lowest group first; others wait their turn
    always_comb
    begin
        grantVec = '0;
        grantIdx = '0;
        found    = 1'b0;
        for (int g = 0; g < GRP_N; g++)
            if (readyVec[g] && !found)
            begin
                grantVec[g] = 1'b1;
                grantIdx    = GRP_AW'(g);
                found       = 1'b1;
            end
    end

    assign grantFn = sid_r[grantIdx][gia_pkg::SID_FN_LSB +: 2];

    // Translate data to function, vector and delivery kind
    always_ff @(posedge core_clk or negedge rstN)
        if (!rstN)
        begin
            sysIntValid_r    <= 1'b0;
            sysIntFunction_r <= 2'h0;
            sysIntVector_r   <= 5'h00;
            sysIntMsi_r      <= 1'b0;
        end
        else
        begin
            sysIntValid_r <= found;
            if (found)
            begin
                sysIntFunction_r <= grantFn;
                sysIntVector_r   <=
                    sid_r[grantIdx][gia_pkg::SID_VEC_W-1:0];
                sysIntMsi_r      <= fnMsiEnable[grantFn]
                                    | fnMsixEnable[grantFn];
            end
        end

    assign sysIntValid    = sysIntValid_r;
    assign sysIntFunction = sysIntFunction_r;
    assign sysIntVector   = sysIntVector_r;
    assign sysIntMsi      = sysIntMsi_r;

    // ========================================================
    // Block status: sticky events, write one to clear, set wins
    assign statSet[gia_pkg::EV_FIRE]    = found;
    assign statSet[gia_pkg::EV_BADADDR] = req && !hit;
    assign statClr = (wrEn && wb_adr_i == gia_pkg::OFF_ISTAT)
                     ? wrMerged[SW-1:0] : '0;

    always_ff @(posedge core_clk or negedge rstN)
        if (!rstN)
            stat_r <= '0;
        else
            stat_r <= (stat_r & ~statClr) | statSet;

    always_ff @(posedge core_clk or negedge rstN)
        if (!rstN)
            mask_r <= '0;
        else if (wrEn && wb_adr_i == gia_pkg::OFF_IMASK)
            mask_r <= wrMerged[SW-1:0];

    // Level output, one flop behind the status bits
    always_ff @(posedge core_clk or negedge rstN)
        if (!rstN)
            irq_r <= 1'b0;
        else
            irq_r <= |(stat_r & mask_r);

    assign irq = irq_r;

    // ========================================================
    // Checks
    chk_ack_single: assert property (
        wb_cyc_i && wb_stb_i && !wbAck_r |=> wbAck_r ##1 !wbAck_r)
        else $error("ack not a one-cycle answer");
    chk_fire_conds: assert property (
        found |-> armedVec[grantIdx] && timerVec[grantIdx] == '0
                  && anyFlag[grantIdx])
        else $error("group fired without all conditions");
    chk_mask_blocks: assert property (
        allMasked |-> grantVec == '0)
        else $error("masked sources raised an interrupt");
    chk_issue_data: assert property (
        found |=> sysIntValid_r
            && sysIntFunction_r == $past(grantFn)
            && sysIntVector_r == $past(sid_r[grantIdx][4:0]))
        else $error("issued data does not match group");
    chk_msi_kind: assert property (
        found |=> sysIntMsi_r == $past(fnMsiEnable[grantFn]
                                       | fnMsixEnable[grantFn]))
        else $error("wrong delivery kind");
    chk_set_wins: assert property (
        statSet[gia_pkg::EV_FIRE] |=> stat_r[gia_pkg::EV_FIRE])
        else $error("event lost against clear");
    chk_irq_level: assert property (
        |(stat_r & mask_r) && $stable(stat_r & mask_r) |=> irq_r)
        else $error("irq not raised for unmasked status");
endmodule : gia_top

//--- tb/gia_pcie_model.sv
`timescale 1ns/100ps

// ========================================================
// Far side: PCI Express interrupt signalling, records issues
module gia_pcie_model
(
    input  wire logic       core_clk,
    input  wire logic       msiOn,
    input  wire logic       sysIntValid,
    input  wire logic [1:0] sysIntFunction,
    input  wire logic [4:0] sysIntVector,
    input  wire logic       sysIntMsi,
    output      logic [3:0] fnMsiEnable,
    output      logic [3:0] fnMsixEnable,
    output      logic [7:0] fireCount,
    output      logic [7:0] lastInt
);
    initial
    begin
        fnMsiEnable  = 4'h0;
        fnMsixEnable = 4'h0;
        fireCount    = 8'h00;
        lastInt      = 8'h00;
    end

    // Config space enables, MSI on function 2, MSI-X on function 0
    always @(posedge core_clk)
    begin
        fnMsiEnable  <= msiOn ? 4'h4 : 4'h0;
        fnMsixEnable <= msiOn ? 4'h1 : 4'h0;
        if (sysIntValid)
        begin
            fireCount <= fireCount + 8'h01;
            lastInt   <= {sysIntMsi, sysIntFunction, sysIntVector};
        end
    end
endmodule : gia_pcie_model

//--- tb/grouped_interrupt_arm_timer_bench.sv
`timescale 1ns/100ps

// ========================================================
// Bench
module grouped_interrupt_arm_timer_bench;
    logic                           core_clk = 1'b0;
    logic                           nrst     = 1'b0;
    logic [11:0]                    adr      = 12'h000;
    logic [31:0]                    wdat     = 32'h0000_0000;
    logic                           we       = 1'b0;
    logic                           cyc      = 1'b0;
    logic [gia_pkg::SRC_N-1:0][3:0] cond     = '0;
    logic                           msiOn    = 1'b1;
    logic [31:0]                    rdat;
    logic                           ack;
    logic                           irq;
    logic                           intValid;
    logic                           intMsi;
    logic [1:0]                     intFn;
    logic [4:0]                     intVec;
    logic [3:0]                     msiEn;
    logic [3:0]                     msixEn;
    logic [7:0]                     fireCount;
    logic [7:0]                     lastInt;
    int                             errTotal   = 0;
    int                             checkCount = 0;

    always #2.5 core_clk = ~core_clk;

    gia_top i_dut (.core_clk(core_clk), .nrst(nrst), .wb_adr_i(adr),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(4'hF),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_ack_o(ack),
        .sourceCondition(cond), .fnMsiEnable(msiEn),
        .fnMsixEnable(msixEn), .sysIntValid(intValid),
        .sysIntFunction(intFn), .sysIntVector(intVec),
        .sysIntMsi(intMsi), .irq(irq));

    gia_pcie_model i_far (.core_clk(core_clk), .msiOn(msiOn),
        .sysIntValid(intValid), .sysIntFunction(intFn),
        .sysIntVector(intVec), .sysIntMsi(intMsi), .fnMsiEnable(msiEn),
        .fnMsixEnable(msixEn), .fireCount(fireCount), .lastInt(lastInt));

    // ========================================================
    // Shared tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checkCount++;
        if (got !== exp)
        begin
            errTotal++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask : check

    // Classic cycle; held until ack is sampled, one idle cycle after
    task automatic wb(input logic [11:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] q);
        @(posedge core_clk);
        adr  <= a;
        we   <= w;
        wdat <= d;
        cyc  <= 1'b1;
        do @(posedge core_clk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        we  <= 1'b0;
    endtask : wb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(a, 1'b1, d, q);
    endtask : wr

    task automatic rdChk(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(a, 1'b0, 32'h0000_0000, q);
        check(q, e);
    endtask : rdChk

    // Cycles until the far side sees an issue, capped at n
    task automatic waitFire(input int n, output int t);
        logic [7:0] c0;
        c0 = fireCount;
        t  = 0;
        while (fireCount === c0 && t < n)
        begin
            @(posedge core_clk);
            t++;
        end
    endtask : waitFire

    // ========================================================
    // Scenarios
    task automatic testReset;
        rdChk(12'h00C, 32'h0000_0300);
        rdChk(12'hC14, 32'h0000_0000);
        rdChk(12'h814, 32'h0000_0000);
    endtask : testReset

    // Timer of two ticks: quiet for at least one tick, then one issue
    task automatic testFire;
        int          t;
        logic [31:0] q;
        wr(12'h00C, 32'h000F_0005);
        wr(12'hC14, 32'h0000_005A);
        cond[3][2] <= 1'b1;
        rdChk(12'h414, 32'h0000_0080);
        rdChk(12'h410, 32'h0000_0000);
        wr(12'h814, 32'h8000_0002);
        wb(12'h814, 1'b0, 32'h0000_0000, q);
        check(32'(q[31]), 32'h1);
        waitFire(150, t);
        check(32'(t), 32'h96);
        waitFire(300, t);
        check(32'(t < 300), 32'h1);
        check(32'(lastInt), 32'h0000_00DA);
        rdChk(12'h814, 32'h0000_0000);
        waitFire(300, t);
        check(32'(t), 32'h12C);
        rdChk(12'hF00, 32'h0000_0001);
        check(32'(irq), 32'h0);
        wr(12'hF04, 32'h0000_0001);
        rdChk(12'hF04, 32'h0000_0001);
        check(32'(irq), 32'h1);
        wr(12'hF00, 32'h0000_0001);
        rdChk(12'hF00, 32'h0000_0000);
        check(32'(irq), 32'h0);
    endtask : testFire

    // Masked member stays visible but silent; legacy once unmasked
    task automatic testMask;
        int t;
        msiOn <= 1'b0;
        wr(12'h00C, 32'h000F_0305);
        wr(12'h814, 32'h8000_0000);
        waitFire(60, t);
        check(32'(t), 32'h3C);
        rdChk(12'h414, 32'h0000_0080);
        wr(12'h00C, 32'h000F_0005);
        waitFire(20, t);
        check(32'(t < 20), 32'h1);
        check(32'(lastInt), 32'h0000_005A);
        cond[3][2] <= 1'b0;
        rdChk(12'h414, 32'h0000_0000);
        wr(12'h814, 32'h8000_0000);
        waitFire(60, t);
        check(32'(t), 32'h3C);
        wr(12'h814, 32'h0000_0000);
    endtask : testMask

    // Unmapped access flags status; last group reachable
    task automatic testEdge;
        wr(12'hF00, 32'h0000_0003);
        rdChk(12'hF08, 32'h0000_0000);
        rdChk(12'hF00, 32'h0000_0002);
        wr(12'hCFC, 32'h0000_007F);
        rdChk(12'hCFC, 32'h0000_007F);
    endtask : testEdge

    // ========================================================
    // Verdict, sequence and watchdog
    task automatic report_and_stop;
        if (errTotal == 0 && checkCount > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop

    initial
    begin
        repeat (3) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge core_clk);
        testReset();
        testFire();
        testMask();
        testEdge();
        report_and_stop();
    end

    // Whole run needs about 900 cycles
    initial
    begin
        repeat (5000) @(posedge core_clk);
        errTotal++;
        report_and_stop();
    end
endmodule : grouped_interrupt_arm_timer_bench
